// File: hdl/ust_pkg.sv
// constants shared by the serial status block
`default_nettype none
package ust_pkg;
	// ========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_RX_TIMEOUT = 8'h14;
	localparam logic [7:0] OFF_ACTION_REQ = 8'h18;
	localparam logic [7:0] OFF_EVENT_STS = 8'h1c;
	localparam logic [7:0] OFF_FLAG_CLEAR = 8'h20;
	localparam logic [7:0] OFF_DATA_WORD = 8'h24;
	localparam int ADR_W = 8;
	localparam int ADR_LSB = 2;
	// ========================================
	// widths and reset values
	localparam int TMO_W = 24;
	localparam int DATA_W = 9;
	localparam logic [31:0] STS_RESET = 32'h0200_00c0;
	localparam logic [31:0] RX_TIMEOUT_COUNT_RESET = 32'h0000_0000;
	// ========================================
	// action request bits
	localparam int REQ_AUTOBAUD = 0;
	localparam int REQ_BREAK = 1;
	localparam int REQ_MUTE = 2;
	localparam int REQ_FLUSH = 3;
	// ========================================
	// status bits, clear bits share the position
	localparam int STS_PARITY = 0;
	localparam int STS_FRAMING = 1;
	localparam int STS_NOISE = 2;
	localparam int STS_OVERRUN = 3;
	localparam int STS_IDLE = 4;
	localparam int STS_RX_NE = 5;
	localparam int STS_TX_DONE = 6;
	localparam int STS_TX_EMPTY = 7;
	localparam int STS_CTS_CHG = 9;
	localparam int STS_CTS_LINE = 10;
	localparam int STS_RX_TMO = 11;
	localparam int STS_AUTOBAUD = 15;
	localparam int STS_BREAK = 18;
	localparam int STS_WAKE = 19;
	localparam int STS_FIXED_HI = 25;
endpackage
`default_nettype wire

// File: hdl/ust_tmo_if.sv
// link between status logic and receive timeout counter
`default_nettype none
interface ust_tmo_if;
	import ust_pkg::*;
	logic baud_tick;
	logic restart;
	logic cancel;
	logic [TMO_W-1:0] limit;
	logic expire;
	modport ctrl (output baud_tick, output restart, output cancel, output limit, input expire);
	modport cnt (input baud_tick, input restart, input cancel, input limit, output expire);
endinterface
`default_nettype wire

// File: hdl/ust_timeout.sv
// receive timeout counter in baud clock units
`default_nettype none
module ust_timeout (
	input wire logic clk_i,
	input wire logic rst_i,
	ust_tmo_if.cnt tmo
);
	import ust_pkg::*;

	logic [TMO_W-1:0] cnt_r;
	logic armed_r;
	logic [TMO_W-1:0] cnt_inc;
	logic hit;

	// ========================================
	// count and compare
	assign cnt_inc = cnt_r + {{(TMO_W-1){1'b0}}, 1'b1};
	assign hit = armed_r & tmo.baud_tick & ~tmo.restart & ~tmo.cancel & (cnt_inc >= tmo.limit);
	assign tmo.expire = hit;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r <= '0;
			armed_r <= 1'b0;
		end
		else if (tmo.restart)
		begin
			cnt_r <= '0;
			armed_r <= 1'b1;
		end
		else if (tmo.cancel || hit)
		begin
			armed_r <= 1'b0;
		end
		else if (armed_r && tmo.baud_tick)
		begin
			cnt_r <= cnt_inc;
		end
	end
endmodule
`default_nettype wire

// File: hdl/ust_status_top.sv
// status, request and receive timeout logic of the serial transceiver
//
// Chosen here: the Wishbone register port.
`default_nettype none
module ust_status_top #(
	parameter int DW = ust_pkg::DATA_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ust_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic baud_tick_i,
	input wire logic smartcard_mode_i,
	input wire logic cts_flow_enable_i,
	input wire logic cts_n_i,
	input wire logic rx_start_bit_i,
	input wire logic rx_word_valid_i,
	input wire logic [DW-1:0] rx_word_i,
	input wire logic parity_err_i,
	input wire logic framing_err_i,
	input wire logic noise_i,
	input wire logic idle_detect_i,
	input wire logic tx_shift_load_i,
	input wire logic tx_frame_done_i,
	input wire logic tx_sm_enable_i,
	input wire logic break_sent_i,
	input wire logic autobaud_done_i,
	input wire logic wake_i,
	output logic [DW-1:0] tx_data_o,
	output logic tx_write_o,
	output logic autobaud_request_o,
	output logic break_send_o,
	output logic mute_enter_o,
	output logic [31:0] event_status_o
);
	import ust_pkg::*;

	// ========================================
	// bus slave decode
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] wmask;
	logic bus_req;
	logic wr_fire;
	logic rd_fire;
	logic sel_rx_timeout_count;
	logic sel_req;
	logic sel_sts;
	logic sel_clr;
	logic sel_data;
	logic [31:0] rd_mux;
	logic [31:0] wr_bits;

	assign bus_req = cyc_i & stb_i;
	assign wr_fire = bus_req & we_i & ack_r;
	assign rd_fire = bus_req & ~we_i & ack_r;
	assign sel_rx_timeout_count = adr_i[ADR_W-1:ADR_LSB] == OFF_RX_TIMEOUT[ADR_W-1:ADR_LSB];
	assign sel_req = adr_i[ADR_W-1:ADR_LSB] == OFF_ACTION_REQ[ADR_W-1:ADR_LSB];
	assign sel_sts = adr_i[ADR_W-1:ADR_LSB] == OFF_EVENT_STS[ADR_W-1:ADR_LSB];
	assign sel_clr = adr_i[ADR_W-1:ADR_LSB] == OFF_FLAG_CLEAR[ADR_W-1:ADR_LSB];
	assign sel_data = adr_i[ADR_W-1:ADR_LSB] == OFF_DATA_WORD[ADR_W-1:ADR_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{sel_i[gi]}};
		end
	endgenerate

	assign wr_bits = dat_i & wmask;

	// ========================================
	// register state
	logic [TMO_W-1:0] rx_timeout_count_r;
	logic [DW-1:0] rx_data_r;
	logic [DW-1:0] tx_data_r;
	logic tx_write_r;
	logic parity_r;
	logic framing_r;
	logic noise_r;
	logic overrun_r;
	logic idle_r;
	logic rx_ne_r;
	logic tx_done_r;
	logic tx_empty_r;
	logic cts_chg_r;
	logic rx_tmo_r;
	logic autobaud_r;
	logic break_r;
	logic wake_r;
	logic [TMO_W-1:0] rx_timeout_count_nxt;

	// ========================================
	// request and clear pulses
	logic [31:0] req_pulse;
	logic [31:0] clr_pulse;
	logic data_wr;
	logic data_rd;

	assign req_pulse = (wr_fire && sel_req) ? wr_bits : 32'h0000_0000;
	assign clr_pulse = (wr_fire && sel_clr) ? wr_bits : 32'h0000_0000;
	assign data_wr = wr_fire & sel_data;
	assign data_rd = rd_fire & sel_data;
	assign rx_timeout_count_nxt = (rx_timeout_count_r & ~wmask[TMO_W-1:0]) | wr_bits[TMO_W-1:0];

	// ========================================
	// clear-to-send pin synchroniser
	logic cts_s1_r;
	logic cts_s2_r;
	logic cts_s3_r;
	logic cts_change;

	assign cts_change = cts_flow_enable_i & (cts_s2_r ^ cts_s3_r);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cts_s1_r <= 1'b1;
			cts_s2_r <= 1'b1;
			cts_s3_r <= 1'b1;
		end
		else
		begin
			cts_s1_r <= cts_n_i;
			cts_s2_r <= cts_s1_r;
			cts_s3_r <= cts_s2_r;
		end
	end

	// ========================================
	// receive timeout counter
	ust_tmo_if tmo ();

	assign tmo.baud_tick = baud_tick_i;
	assign tmo.limit = rx_timeout_count_r;
	assign tmo.restart = smartcard_mode_i ? rx_start_bit_i : rx_word_valid_i;
	assign tmo.cancel = ~smartcard_mode_i & rx_start_bit_i;

	ust_timeout i_ust_timeout (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tmo(tmo)
	);

	// ========================================
	// flag next values, set wins over clear
	logic overrun_set;
	logic rx_load;

	assign overrun_set = rx_word_valid_i & rx_ne_r & ~data_rd & ~req_pulse[REQ_FLUSH];
	assign rx_load = rx_word_valid_i & ~overrun_set;

	logic parity_nxt;
	logic framing_nxt;
	logic noise_nxt;
	logic overrun_nxt;
	logic idle_nxt;
	logic rx_ne_nxt;
	logic tx_done_nxt;
	logic tx_empty_nxt;
	logic cts_chg_nxt;
	logic rx_tmo_nxt;
	logic autobaud_nxt;
	logic break_nxt;
	logic wake_nxt;

	assign parity_nxt = parity_err_i | (parity_r & ~clr_pulse[STS_PARITY]);
	assign framing_nxt = framing_err_i | (framing_r & ~clr_pulse[STS_FRAMING]);
	assign noise_nxt = noise_i | (noise_r & ~clr_pulse[STS_NOISE]);
	assign overrun_nxt = overrun_set | (overrun_r & ~clr_pulse[STS_OVERRUN]);
	assign idle_nxt = idle_detect_i | (idle_r & ~clr_pulse[STS_IDLE]);
	assign rx_ne_nxt = rx_word_valid_i | (rx_ne_r & ~data_rd & ~req_pulse[REQ_FLUSH]);
	assign tx_done_nxt = (tx_frame_done_i & tx_empty_r) | (tx_done_r & ~data_wr & ~clr_pulse[STS_TX_DONE]);
	assign tx_empty_nxt = tx_shift_load_i | (tx_empty_r & ~data_wr);
	assign cts_chg_nxt = cts_change | (cts_chg_r & ~clr_pulse[STS_CTS_CHG]);
	assign rx_tmo_nxt = tmo.expire | (rx_tmo_r & ~clr_pulse[STS_RX_TMO]);
	assign autobaud_nxt = autobaud_done_i | (autobaud_r & ~req_pulse[REQ_AUTOBAUD]);
	assign break_nxt = req_pulse[REQ_BREAK] | (break_r & ~break_sent_i);
	assign wake_nxt = wake_i | (wake_r & ~req_pulse[REQ_MUTE]);

	// ========================================
	// status word
	logic [31:0] sts_word;

	always_comb
	begin
		sts_word = 32'h0000_0000;
		sts_word[STS_PARITY] = parity_r;
		sts_word[STS_FRAMING] = framing_r;
		sts_word[STS_NOISE] = noise_r;
		sts_word[STS_OVERRUN] = overrun_r;
		sts_word[STS_IDLE] = idle_r;
		sts_word[STS_RX_NE] = rx_ne_r;
		sts_word[STS_TX_DONE] = tx_done_r;
		sts_word[STS_TX_EMPTY] = tx_empty_r;
		sts_word[STS_CTS_CHG] = cts_chg_r;
		sts_word[STS_CTS_LINE] = ~cts_s2_r;
		sts_word[STS_RX_TMO] = rx_tmo_r;
		sts_word[STS_AUTOBAUD] = autobaud_r;
		sts_word[STS_BREAK] = break_r;
		sts_word[STS_WAKE] = wake_r;
		sts_word[STS_FIXED_HI] = STS_RESET[STS_FIXED_HI];
	end

	// ========================================
	// read data selection
	assign rd_mux = sel_rx_timeout_count ? {{(32-TMO_W){1'b0}}, rx_timeout_count_r} :
		sel_sts ? sts_word :
		sel_data ? {{(32-DW){1'b0}}, rx_data_r} :
		32'h0000_0000;

	// ========================================
	// bus handshake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= bus_req & ~ack_r;
			dat_r <= (bus_req && !ack_r && !we_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// ========================================
	// data and timeout registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_timeout_count_r <= RX_TIMEOUT_COUNT_RESET[TMO_W-1:0];
			rx_data_r <= '0;
			tx_data_r <= '0;
			tx_write_r <= 1'b0;
		end
		else
		begin
			if (wr_fire && sel_rx_timeout_count)
				rx_timeout_count_r <= rx_timeout_count_nxt;
			if (rx_load)
				rx_data_r <= rx_word_i;
			else if (req_pulse[REQ_FLUSH])
				rx_data_r <= '0;
			if (data_wr)
				tx_data_r <= wr_bits[DW-1:0];
			tx_write_r <= data_wr;
		end
	end

	// ========================================
	// status flags
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			parity_r <= STS_RESET[STS_PARITY];
			framing_r <= STS_RESET[STS_FRAMING];
			noise_r <= STS_RESET[STS_NOISE];
			overrun_r <= STS_RESET[STS_OVERRUN];
			idle_r <= STS_RESET[STS_IDLE];
			rx_ne_r <= STS_RESET[STS_RX_NE];
			tx_done_r <= STS_RESET[STS_TX_DONE];
			tx_empty_r <= STS_RESET[STS_TX_EMPTY];
			cts_chg_r <= STS_RESET[STS_CTS_CHG];
			rx_tmo_r <= STS_RESET[STS_RX_TMO];
			autobaud_r <= STS_RESET[STS_AUTOBAUD];
			break_r <= STS_RESET[STS_BREAK];
			wake_r <= STS_RESET[STS_WAKE];
		end
		else
		begin
			parity_r <= parity_nxt;
			framing_r <= framing_nxt;
			noise_r <= noise_nxt;
			overrun_r <= overrun_nxt;
			idle_r <= idle_nxt;
			rx_ne_r <= rx_ne_nxt;
			tx_done_r <= tx_done_nxt;
			tx_empty_r <= tx_empty_nxt;
			cts_chg_r <= cts_chg_nxt;
			rx_tmo_r <= rx_tmo_nxt;
			autobaud_r <= autobaud_nxt;
			break_r <= break_nxt;
			wake_r <= wake_nxt;
		end
	end

	// ========================================
	// action outputs
	logic autobaud_q_r;
	logic mute_q_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			autobaud_q_r <= 1'b0;
			mute_q_r <= 1'b0;
		end
		else
		begin
			autobaud_q_r <= req_pulse[REQ_AUTOBAUD];
			mute_q_r <= req_pulse[REQ_MUTE];
		end
	end

	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign tx_data_o = tx_data_r;
	assign tx_write_o = tx_write_r;
	assign autobaud_request_o = autobaud_q_r;
	assign mute_enter_o = mute_q_r;
	assign break_send_o = break_r & tx_sm_enable_i;
	assign event_status_o = sts_word;
endmodule
`default_nettype wire

// File: bench/ust_status_sva.sv
// assertion checker for the serial status block
`default_nettype none
module ust_status_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ust_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic rx_word_valid_i,
	input wire logic parity_err_i,
	input wire logic tx_shift_load_i,
	input wire logic cts_flow_enable_i,
	input wire logic cts_n_i,
	input wire logic wake_i,
	input wire logic tx_sm_enable_i,
	input wire logic autobaud_request_o,
	input wire logic mute_enter_o,
	input wire logic break_send_o,
	input wire logic [31:0] event_status_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ust_pkg::*;
	wire bus_wr = ack_o && cyc_i && stb_i && we_i && sel_i[0];
	wire wr_req = bus_wr && adr_i[7:2] == OFF_ACTION_REQ[7:2];
	wire wr_clr = bus_wr && adr_i[7:2] == OFF_FLAG_CLEAR[7:2];
	wire tmo_clr = ack_o && cyc_i && stb_i && we_i && sel_i[1] && adr_i[7:2] == OFF_FLAG_CLEAR[7:2];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ========================================
	// bus handshake, flags and requests
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	property p_pclr; wr_clr && dat_i[0] && !parity_err_i |=> !event_status_o[0]; endproperty
	a_pclr: assert property (p_pclr) else $error("parity flag not cleared");
	property p_rxne; rx_word_valid_i |=> event_status_o[5]; endproperty
	a_rxne: assert property (p_rxne) else $error("rx not empty missing");
	property p_ovr; rx_word_valid_i && event_status_o[5] && !ack_o |=> event_status_o[3]; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun missing");
	property p_txe; tx_shift_load_i |=> event_status_o[7]; endproperty
	a_txe: assert property (p_txe) else $error("tx empty missing");
	property p_ctsl; $fell(cts_n_i) |-> ##2 event_status_o[10]; endproperty
	a_ctsl: assert property (p_ctsl) else $error("cts line state wrong");
	property p_ctsc; cts_flow_enable_i && $changed(cts_n_i) |-> ##3 event_status_o[9]; endproperty
	a_ctsc: assert property (p_ctsc) else $error("cts change missing");
	property p_abr; wr_req && dat_i[0] |=> autobaud_request_o ##1 !autobaud_request_o; endproperty
	a_abr: assert property (p_abr) else $error("autobaud pulse wrong");
	property p_mute; wr_req && dat_i[2] && !wake_i |=> mute_enter_o && !event_status_o[19]; endproperty
	a_mute: assert property (p_mute) else $error("mute request wrong");
	property p_brk; break_send_o == (event_status_o[18] && tx_sm_enable_i); endproperty
	a_brk: assert property (p_brk) else $error("break send wrong");
	property p_brkq; wr_req && dat_i[1] |=> event_status_o[18]; endproperty
	a_brkq: assert property (p_brkq) else $error("break pending not set");
	property p_tmoh; event_status_o[11] && !(tmo_clr && dat_i[11]) |=> event_status_o[11]; endproperty
	a_tmoh: assert property (p_tmoh) else $error("timeout flag dropped");
	property p_rst; disable iff (1'b0) rst_i |=> event_status_o == STS_RESET; endproperty
	a_rst: assert property (p_rst) else $error("status reset value wrong");
endmodule
bind ust_status_top ust_status_sva i_ust_status_sva (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
	.dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.rx_word_valid_i(rx_word_valid_i), .parity_err_i(parity_err_i), .tx_shift_load_i(tx_shift_load_i),
	.cts_flow_enable_i(cts_flow_enable_i), .cts_n_i(cts_n_i), .wake_i(wake_i), .tx_sm_enable_i(tx_sm_enable_i),
	.autobaud_request_o(autobaud_request_o), .mute_enter_o(mute_enter_o), .break_send_o(break_send_o),
	.event_status_o(event_status_o));
`default_nettype wire

// File: bench/ust_peer.sv
// line side peer model: receive events, baud ticks, clear-to-send pin
`default_nettype none
module ust_peer #(
	parameter int DW = 9
) (
	input wire logic clk_i,
	output logic baud_tick_o,
	output logic rx_start_bit_o,
	output logic [3:0] err_o,
	output logic rx_word_valid_o,
	output logic [DW-1:0] rx_word_o,
	output logic cts_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] ev = '0;
	assign {baud_tick_o, rx_start_bit_o, err_o} = ev;
	initial
	begin
		rx_word_valid_o = 1'b0;
		rx_word_o = '0;
		cts_n_o = 1'b1;
	end
	// ========================================
	// one cycle pulse: 5 tick, 4 start bit, 3:0 errors
	task automatic pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
		#1;
	endtask
	task automatic ticks(input int n);
		repeat (n) pulse(5);
	endtask
	// ========================================
	// word handover, data scrambled once released
	task automatic word(input logic [DW-1:0] w);
		@(posedge clk_i);
		rx_word_o <= w;
		rx_word_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_word_valid_o <= 1'b0;
		rx_word_o <= ~w;
		#1;
	endtask
	task automatic set_cts(input logic v);
		@(posedge clk_i);
		cts_n_o <= v;
		#1;
	endtask
endmodule
`default_nettype wire

// File: bench/ust_status_top_tb.sv
// self-checking bench for the serial status block
`default_nettype none
module ust_status_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ust_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic we_i = 1'b0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic sc_mode = 1'b0;
	logic cts_en = 1'b0;
	logic tx_en = 1'b0;
	logic ack_o, tx_write_o, abr_o, brk_o, mute_o, tick, start, vld, cts_n;
	logic [7:0] adr_i = '0;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o, event_status_o, rd, rv;
	logic [3:0] sel_i = '0;
	logic [3:0] err;
	logic [4:0] dev = '0;
	logic [DATA_W-1:0] rx_word, tx_data_o, w1;
	int err_count = 0;
	int checks_done = 0;
	int t;
	int eb[4] = '{0, 1, 2, 4};
	initial
	begin
		forever #4 clk_i = ~clk_i;
	end
	ust_status_top #(.DW(DATA_W)) i_ust_status_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .baud_tick_i(tick),
		.smartcard_mode_i(sc_mode), .cts_flow_enable_i(cts_en), .cts_n_i(cts_n), .rx_start_bit_i(start),
		.rx_word_valid_i(vld), .rx_word_i(rx_word), .parity_err_i(err[0]), .framing_err_i(err[1]), .noise_i(err[2]),
		.idle_detect_i(err[3]), .tx_shift_load_i(dev[0]), .tx_frame_done_i(dev[1]), .tx_sm_enable_i(tx_en),
		.break_sent_i(dev[2]), .autobaud_done_i(dev[3]), .wake_i(dev[4]), .tx_data_o(tx_data_o),
		.tx_write_o(tx_write_o), .autobaud_request_o(abr_o), .break_send_o(brk_o), .mute_enter_o(mute_o),
		.event_status_o(event_status_o));
	ust_peer #(.DW(DATA_W)) i_ust_peer (.clk_i(clk_i), .baud_tick_o(tick), .rx_start_bit_o(start), .err_o(err),
		.rx_word_valid_o(vld), .rx_word_o(rx_word), .cts_n_o(cts_n));
	// ========================================
	// compare, bus cycle and verdict
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bit_chk(input string s, input int b, input logic e);
		chk(s, {31'h0, e}, {31'h0, event_status_o[b]});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hf};
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		if (ack_o !== 1'b1)
		begin
			err_count++;
			give_verdict();
		end
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
		#1;
	endtask
	task automatic dp(input int k);
		@(posedge clk_i);
		dev[k] <= 1'b1;
		@(posedge clk_i);
		dev[k] <= 1'b0;
		#1;
	endtask
	// ========================================
	// main sequence
	initial
	begin
		rv = $urandom(32'hd91c);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, OFF_EVENT_STS, 0);
		chk("status", STS_RESET, rd);
		wb(0, OFF_RX_TIMEOUT, 0);
		chk("timeout value", RX_TIMEOUT_COUNT_RESET, rd);
		wb(0, 8'h40, 0);
		chk("unmapped", 0, rd);
		$display("done: reset");
		t = 2 + $urandom % 4;
		w1 = DATA_W'($urandom);
		wb(1, OFF_RX_TIMEOUT, ($urandom & 32'hff00_0000) | t);
		wb(0, OFF_RX_TIMEOUT, 0);
		chk("timeout value", t, rd);
		i_ust_peer.word(w1);
		i_ust_peer.ticks(t - 1);
		bit_chk("timeout early", STS_RX_TMO, 0);
		i_ust_peer.ticks(1);
		bit_chk("timeout", STS_RX_TMO, 1);
		wb(1, OFF_FLAG_CLEAR, 0);
		bit_chk("timeout held", STS_RX_TMO, 1);
		wb(1, OFF_FLAG_CLEAR, 32'h0000_0800);
		bit_chk("timeout clear", STS_RX_TMO, 0);
		wb(1, OFF_ACTION_REQ, 32'h0000_0008);
		i_ust_peer.word(w1);
		bit_chk("flushed no overrun", STS_OVERRUN, 0);
		i_ust_peer.pulse(4);
		i_ust_peer.ticks(t + 2);
		bit_chk("timeout cancelled", STS_RX_TMO, 0);
		@(posedge clk_i) sc_mode <= 1'b1;
		i_ust_peer.pulse(4);
		i_ust_peer.ticks(t - 1);
		bit_chk("card early", STS_RX_TMO, 0);
		i_ust_peer.ticks(1);
		bit_chk("card timeout", STS_RX_TMO, 1);
		wb(1, OFF_FLAG_CLEAR, 32'h0000_0800);
		@(posedge clk_i) sc_mode <= 1'b0;
		wb(1, OFF_ACTION_REQ, 32'h0000_0008);
		$display("done: timeout");
		for (int i = 0; i < 4; i++)
		begin
			i_ust_peer.pulse(i);
			bit_chk("error flag", eb[i], 1);
			wb(1, OFF_FLAG_CLEAR, $urandom & ~(32'h1 << eb[i]));
			bit_chk("error held", eb[i], 1);
			wb(1, OFF_FLAG_CLEAR, 32'h1 << eb[i]);
			bit_chk("error clear", eb[i], 0);
		end
		$display("done: errors");
		i_ust_peer.word(w1);
		bit_chk("rx not empty", STS_RX_NE, 1);
		i_ust_peer.word(~w1);
		bit_chk("overrun", STS_OVERRUN, 1);
		wb(0, OFF_DATA_WORD, 0);
		chk("rx word", 32'(w1), rd);
		bit_chk("rx read", STS_RX_NE, 0);
		wb(1, OFF_FLAG_CLEAR, 32'h0000_0008);
		i_ust_peer.word(w1);
		wb(1, OFF_ACTION_REQ, 32'h0000_0008);
		bit_chk("flush", STS_RX_NE, 0);
		wb(0, OFF_DATA_WORD, 0);
		chk("flushed word", 0, rd);
		i_ust_peer.word(w1);
		bit_chk("no overrun", STS_OVERRUN, 0);
		$display("done: receive");
		rv = $urandom;
		wb(1, OFF_DATA_WORD, rv);
		chk("tx data", 32'(rv[DATA_W-1:0]), 32'(tx_data_o));
		chk("tx write", 1, 32'(tx_write_o));
		chk("tx flags", 0, 32'(event_status_o[7:6]));
		dp(0);
		bit_chk("tx empty", STS_TX_EMPTY, 1);
		dp(1);
		bit_chk("tx complete", STS_TX_DONE, 1);
		wb(1, OFF_FLAG_CLEAR, 32'h0000_0040);
		bit_chk("tx complete clear", STS_TX_DONE, 0);
		$display("done: transmit");
		dp(3);
		bit_chk("autobaud set", STS_AUTOBAUD, 1);
		wb(1, OFF_ACTION_REQ, 32'h0000_0001);
		bit_chk("autobaud flag", STS_AUTOBAUD, 0);
		chk("autobaud pulse", 1, 32'(abr_o));
		wb(1, OFF_ACTION_REQ, 32'h0000_0002);
		bit_chk("break pending", STS_BREAK, 1);
		chk("break idle", 0, 32'(brk_o));
		@(posedge clk_i) tx_en <= 1'b1;
		#1 chk("break send", 1, 32'(brk_o));
		dp(2);
		bit_chk("break done", STS_BREAK, 0);
		dp(4);
		bit_chk("wake", STS_WAKE, 1);
		wb(1, OFF_ACTION_REQ, 32'h0000_0004);
		bit_chk("mute", STS_WAKE, 0);
		chk("mute pulse", 1, 32'(mute_o));
		wb(0, OFF_ACTION_REQ, 0);
		chk("request read", 0, rd);
		$display("done: requests");
		i_ust_peer.set_cts(0);
		repeat (4) @(posedge clk_i);
		#1 chk("cts off", 32'h0000_0400, event_status_o & 32'h0000_0600);
		@(posedge clk_i) cts_en <= 1'b1;
		i_ust_peer.set_cts(1);
		repeat (4) @(posedge clk_i);
		#1 chk("cts", 32'h0000_0200, event_status_o & 32'h0000_0600);
		wb(1, OFF_FLAG_CLEAR, 32'h0000_0200);
		bit_chk("cts clear", STS_CTS_CHG, 0);
		$display("done: cts");
		give_verdict();
	end
endmodule
`default_nettype wire
